// ---- bench/cfx_mem_model.sv ----
// character memory behind the execution core, with adjustable wait states
`timescale 1ns/1ps
module cfx_mem_model (
  input  wire logic                  sys_clk_i,
  input  wire logic                  nrst_i,
  input  wire cfx_pkg::cfx_mem_req_t mem_i,
  input  wire logic [3:0]            lat_i,
  output logic                       ack_o,
  output logic [cfx_pkg::CHAR_W-1:0] rdata_o
);
  logic [cfx_pkg::CHAR_W-1:0] mem [1 << cfx_pkg::ADDR_W];
  logic [3:0]                 wait_cnt;

  // read data toggles outside an answer so stale values never look right
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o <= 6'h2a;
    end else if (ack_o || !mem_i.req) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o <= ~rdata_o;
    end else if (wait_cnt < lat_i) begin
      wait_cnt <= wait_cnt + 4'h1;
      rdata_o <= ~rdata_o;
    end else begin
      ack_o <= 1'b1;
      if (mem_i.we) begin
        mem[mem_i.addr] <= mem_i.wdata;
        rdata_o <= ~rdata_o;
      end else begin
        rdata_o <= mem[mem_i.addr];
      end
    end
  end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the execution core and its fifo
`timescale 1ns/1ps
module testbench;
  logic                       sys_clk;
  logic                       nrst;
  cfx_pkg::cfx_cmd_t          cmd;
  logic                       cmd_valid;
  logic                       cmd_ready;
  logic [cfx_pkg::ADDR_W-1:0] index [cfx_pkg::IDX_N];
  logic [cfx_pkg::ADDR_W-1:0] icount;
  cfx_pkg::cfx_mem_req_t      mem_req;
  logic                       mem_ack;
  logic [cfx_pkg::CHAR_W-1:0] mem_rdata;
  logic [cfx_pkg::ADDR_W-1:0] icount_out;
  logic                       icount_load;
  logic                       done;
  logic [cfx_pkg::TIME_W-1:0] op_time;
  logic [3:0]                 lat;
  logic                       in_bt;
  logic [cfx_pkg::ADDR_W-1:0] last_wr;
  logic [cfx_pkg::ADDR_W-1:0] load_val;
  int                         n_fail;
  int                         cmp_count;
  int                         n_load;
  int                         n_wr;

  cfx_core uut (
    .sys_clk_i     (sys_clk),
    .nrst_i        (nrst),
    .cmd_i         (cmd),
    .cmd_valid_i   (cmd_valid),
    .cmd_ready_o   (cmd_ready),
    .index_i       (index),
    .icount_i      (icount),
    .mem_o         (mem_req),
    .mem_ack_i     (mem_ack),
    .mem_rdata_i   (mem_rdata),
    .icount_o      (icount_out),
    .icount_load_o (icount_load),
    .done_o        (done),
    .time_o        (op_time)
  );
  cfx_mem_model mdl (
    .sys_clk_i (sys_clk),
    .nrst_i    (nrst),
    .mem_i     (mem_req),
    .lat_i     (lat),
    .ack_o     (mem_ack),
    .rdata_o   (mem_rdata)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [5:0] init_ch(input logic [14:0] a);
    return a[5:0] ^ 6'h15;
  endfunction

  function automatic cfx_pkg::cfx_cmd_t mk(input cfx_pkg::cfx_op_t op, input logic [14:0] a,
      input logic [2:0] x, input logic [4:0] l, input logic [5:0] k, input logic [1:0] nc,
      input logic [2:0] s, input logic d);
    return '{op: op, addr: a, idx_sel: x, len: l, konst: k, n_code: nc, shift: s, dollar: d};
  endfunction

  // one command: hold valid until taken, then wait for the done pulse
  task automatic run(input cfx_pkg::cfx_cmd_t c);
    int n;
    n = 0;
    cmd = c;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 5000) begin
      n_fail++;
      $display("BAD %0t no completion", $time);
    end
  endtask

  // data writes of a transfer, low-memory pointer area excluded
  always @(posedge sys_clk) begin
    if (icount_load === 1'b1) begin
      n_load++;
      load_val = icount_out;
    end
    if (in_bt && mem_ack && mem_req.we && mem_req.addr[14:4] != 11'h004) begin
      if (n_wr > 0) chk(mem_req.addr, last_wr + 15'h0001);
      last_wr = mem_req.addr;
      n_wr++;
    end
  end

  initial begin
    #200000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [14:0]       a;
    logic [14:0]       ea;
    logic [14:0]       src;
    logic [14:0]       dst;
    logic [5:0]        b;
    logic [5:0]        ptr;
    logic [31:0]       v;
    logic [5:0]        expq [64];
    logic [4:0]        ln;
    logic [2:0]        s;
    cfx_pkg::cfx_op_t  op;
    int                e;
    n_fail = 0;
    cmp_count = 0;
    n_load = 0;
    n_wr = 0;
    in_bt = 1'b0;
    lat = 4'h0;
    nrst = 1'b0;
    cmd = '0;
    cmd_valid = 1'b0;
    icount = 15'h0023;
    // selector zero must ignore a nonzero index 0
    for (int i = 0; i < 8; i++) index[i] = 15'(15'h0100 * (i + 1));
    for (int i = 0; i < 32768; i++) mdl.mem[i] = init_ch(15'(i));
    repeat (3) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    for (int p = 0; p < 2; p++) begin
      lat = p ? 4'h2 : 4'h0;
      ln = p ? 5'h10 : 5'h01;
      run(mk(p ? cfx_pkg::CFX_OP_PAD_BLANKS : cfx_pkg::CFX_OP_PAD_ZEROS, 15'h0200, 3'h2, ln,
             6'h00, 2'h0, 3'h0, 1'b0));
      for (int i = 0; i <= ln + 1; i++) begin
        a = 15'(15'h0501 - i);
        chk(mdl.mem[a], (i == 0 || i == ln + 1) ? init_ch(a) :
            (p ? cfx_pkg::CH_BLANK : cfx_pkg::CH_ZERO));
      end
    end
    for (int k = 0; k < 4; k++) begin
      lat = 4'(k);
      a = 15'(15'h0600 + k);
      mdl.mem[a] = 6'(6'h15 + 6'h11 * k);
      b = 6'(6'h33 - 6'h0e * k);
      run(mk(k[0] ? cfx_pkg::CFX_OP_AND : cfx_pkg::CFX_OP_OR, a, 3'h0, 5'h00, b, 2'h0,
             3'h0, 1'b0));
      chk(mdl.mem[a], k[0] ? (6'(6'h15 + 6'h11 * k) & b) : (6'(6'h15 + 6'h11 * k) | b));
      chk(op_time, cfx_pkg::T_LOG_X10 / 10);
    end
    for (int c = 0; c < 4; c++) begin
      lat = 4'(3 - c);
      s = 3'(7 * c);
      ea = 15'(15'h0700 + 8 * c);
      v = 32'h0;
      for (int i = 0; i <= c; i++) v = (v << 6) | init_ch(15'(ea + i));
      v = (v << s) & ((32'h1 << (6 * (c + 1))) - 32'h1);
      run(mk(cfx_pkg::CFX_OP_SHIFT, 15'(ea - 15'h0200), 3'h1, 5'h00, 6'h00, 2'(c), s, 1'b0));
      for (int i = 0; i <= c; i++) chk(mdl.mem[15'(ea + i)], (v >> (6 * (c - i))) & 32'h3f);
      chk(op_time, (cfx_pkg::T_SH_BASE_X10 + s * (cfx_pkg::T_SH_BIT_X10 +
          cfx_pkg::T_SH_CODE_X10 * c)) / 10);
    end
    for (int f = 0; f < 4; f++) begin
      lat = 4'(f);
      b = 6'(1 + 15 * f);
      ptr = 6'h08;
      ea = 15'(15'h0c00 + 15'h0040 * f);
      src = f < 2 ? ea : 15'(ptr);
      dst = f < 2 ? 15'(ptr) : ea;
      // pointer and count loaded before the transfer
      mdl.mem[cfx_pkg::DST_ADDR] = ptr;
      mdl.mem[cfx_pkg::SRC_ADDR] = ptr;
      mdl.mem[cfx_pkg::CNT_ADDR] = b;
      for (int i = 0; i < b; i++) expq[i] = mdl.mem[15'(src + i)];
      op = f == 0 ? cfx_pkg::CFX_OP_FROM_RST : f == 1 ? cfx_pkg::CFX_OP_FROM_INC :
           f == 2 ? cfx_pkg::CFX_OP_TO_RST : cfx_pkg::CFX_OP_TO_INC;
      in_bt = 1'b1;
      n_wr = 0;
      n_load = 0;
      run(mk(op, 15'(ea - 15'h0400), 3'h3, 5'h00, 6'h00, 2'h0, 3'h0, 1'b0));
      in_bt = 1'b0;
      for (int i = 0; i < b; i++) chk(mdl.mem[15'(dst + i)], expq[i]);
      chk(n_wr, b);
      chk(mdl.mem[cfx_pkg::CNT_ADDR], b);
      chk(mdl.mem[f < 2 ? cfx_pkg::DST_ADDR : cfx_pkg::SRC_ADDR], f[0] ? 6'(ptr + b) : ptr);
      chk(op_time, ((f[0] ? cfx_pkg::T_BT_INC_X10 : cfx_pkg::T_BT_RST_X10) +
          cfx_pkg::T_BT_CHAR_X10 * b) / 10);
      chk(n_load, 1);
      chk(load_val, icount);
      chk(mdl.mem[cfx_pkg::SAVE_ADDR], icount[5:0]);
    end
    for (int z = 0; z < 3; z++) begin
      e = 3 * (2 - z);
      ln = z[0] ? 5'h08 : 5'h10;
      run(mk(cfx_pkg::CFX_OP_ZS_TIME, 15'h0000, 3'h0, ln, 6'(e), 2'h0, 3'h0, z != 2));
      chk(op_time, (cfx_pkg::T_ZS_BASE_X10 + cfx_pkg::T_ZS_CHAR_X10 * e +
          (z != 2 ? cfx_pkg::T_ZS_ADJ_X10 : 0) - (ln == 5'h10 ? cfx_pkg::T_ZS_ADJ_X10 : 0))
          / 10);
    end
    // reset mid-transfer, then a zero-wait move through the internal fifo
    lat = 4'h1;
    cmd = mk(cfx_pkg::CFX_OP_TO_INC, 15'h0e00, 3'h0, 5'h00, 6'h00, 2'h0, 3'h0, 1'b0);
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    repeat (40) @(posedge sys_clk);
    #1;
    nrst = 1'b0;
    #1;
    chk(mem_req, 32'h0);
    chk(done, 1'b0);
    chk(icount_load, 1'b0);
    chk(cmd_ready, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    lat = 4'h0;
    mdl.mem[cfx_pkg::DST_ADDR] = 6'h30;
    mdl.mem[cfx_pkg::CNT_ADDR] = 6'h04;
    in_bt = 1'b1;
    n_wr = 0;
    n_load = 0;
    run(mk(cfx_pkg::CFX_OP_FROM_RST, 15'h0d00, 3'h0, 5'h00, 6'h00, 2'h0, 3'h0, 1'b0));
    in_bt = 1'b0;
    for (int i = 0; i < 4; i++) chk(mdl.mem[15'(15'h0030 + i)], init_ch(15'(15'h0d00 + i)));
    chk(n_wr, 4);
    chk(mdl.mem[cfx_pkg::DST_ADDR], 6'h30);
    chk(n_load, 1);
    finish_test();
  end
endmodule

// ---- hw/cfx_core.sv ----
// execution sequencer for pad, block transfer, logical and shift operations
`timescale 1ns/1ps
module cfx_core (
  input  wire logic                          sys_clk_i,
  input  wire logic                          nrst_i,
  input  wire cfx_pkg::cfx_cmd_t             cmd_i,
  input  wire logic                          cmd_valid_i,
  output logic                               cmd_ready_o,
  input  wire logic [cfx_pkg::ADDR_W-1:0]    index_i [cfx_pkg::IDX_N],
  input  wire logic [cfx_pkg::ADDR_W-1:0]    icount_i,
  output cfx_pkg::cfx_mem_req_t              mem_o,
  input  wire logic                          mem_ack_i,
  input  wire logic [cfx_pkg::CHAR_W-1:0]    mem_rdata_i,
  output logic [cfx_pkg::ADDR_W-1:0]         icount_o,
  output logic                               icount_load_o,
  output logic                               done_o,
  output logic [cfx_pkg::TIME_W-1:0]         time_o
);
  typedef enum {
    S_IDLE, S_LDW, S_LDWAIT, S_FILL, S_RD, S_RDW, S_WR, S_WRW, S_PTRW, S_SAVE, S_REST,
    S_DONE
  } cfx_state_t;
  typedef struct packed {
    cfx_state_t                 fsm;
    cfx_pkg::cfx_cmd_t          cmd;
    logic [cfx_pkg::ADDR_W-1:0] ea;
    logic [cfx_pkg::ADDR_W-1:0] src;
    logic [cfx_pkg::ADDR_W-1:0] dst;
    logic [cfx_pkg::ADDR_W-1:0] ptr0;
    logic [cfx_pkg::CNT_W-1:0]  left;
    logic [cfx_pkg::CNT_W-1:0]  total;
    logic [1:0]                 wsel;
    logic [1:0]                 byte_i;
    logic [23:0]                acc;
    logic [2:0]                 rd_n;
    logic [cfx_pkg::ADDR_W-1:0] word;
    cfx_pkg::cfx_mem_req_t      mem;
    logic [cfx_pkg::ADDR_W-1:0] icnt;
    logic                       icnt_ld;
    logic                       done;
    logic                       rdy;
    logic [cfx_pkg::TIME_W-1:0] tm;
  } cfx_core_st_t;
  cfx_core_st_t st_reg, st_next;
  logic [cfx_pkg::CHAR_W-1:0] fifo_d;
  logic fifo_v, fifo_rdy, fifo_push, fifo_pop;

  // characters read for block moves, logical and shift operations wait here; write side pops
  cfx_fifo #(.WIDTH(cfx_pkg::CHAR_W), .DEPTH(cfx_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .in_data_i  (mem_rdata_i),
    .in_valid_i (fifo_push),
    .in_ready_o (fifo_rdy),
    .out_data_o (fifo_d),
    .out_valid_o(fifo_v),
    .out_ready_i(fifo_pop)
  );

  function automatic logic is_blk(input cfx_pkg::cfx_op_t op);
    return op inside {cfx_pkg::CFX_OP_FROM_RST, cfx_pkg::CFX_OP_FROM_INC,
                      cfx_pkg::CFX_OP_TO_RST, cfx_pkg::CFX_OP_TO_INC};
  endfunction
  function automatic logic is_inc(input cfx_pkg::cfx_op_t op);
    return op inside {cfx_pkg::CFX_OP_FROM_INC, cfx_pkg::CFX_OP_TO_INC};
  endfunction
  function automatic logic is_from(input cfx_pkg::cfx_op_t op);
    return op inside {cfx_pkg::CFX_OP_FROM_RST, cfx_pkg::CFX_OP_FROM_INC};
  endfunction
  // tenths to whole cycles: one time unit per cycle, rounded down
  function automatic logic [cfx_pkg::TIME_W-1:0] tenths(input int unsigned x10);
    return cfx_pkg::TIME_W'(x10 / 10);
  endfunction
  function automatic logic [cfx_pkg::TIME_W-1:0] op_time(input cfx_pkg::cfx_cmd_t c,
                                                         input logic [9:0] b);
    int unsigned t;
    t = 0;
    case (c.op)
      cfx_pkg::CFX_OP_ZS_TIME: begin
        t = cfx_pkg::T_ZS_BASE_X10 + cfx_pkg::T_ZS_CHAR_X10 * c.konst;
        if (c.dollar) t = t + cfx_pkg::T_ZS_ADJ_X10;
        if (c.len == 5'(cfx_pkg::ZS_FULL_LEN)) t = t - cfx_pkg::T_ZS_ADJ_X10;
      end
      cfx_pkg::CFX_OP_FROM_RST, cfx_pkg::CFX_OP_TO_RST:
        t = cfx_pkg::T_BT_RST_X10 + cfx_pkg::T_BT_CHAR_X10 * b;
      cfx_pkg::CFX_OP_FROM_INC, cfx_pkg::CFX_OP_TO_INC:
        t = cfx_pkg::T_BT_INC_X10 + cfx_pkg::T_BT_CHAR_X10 * b;
      cfx_pkg::CFX_OP_OR, cfx_pkg::CFX_OP_AND: t = cfx_pkg::T_LOG_X10;
      cfx_pkg::CFX_OP_SHIFT:
        t = cfx_pkg::T_SH_BASE_X10 + c.shift *
            (cfx_pkg::T_SH_BIT_X10 + cfx_pkg::T_SH_CODE_X10 * c.n_code);
      default: t = cfx_pkg::T_PAD_BASE_X10 + cfx_pkg::T_PAD_CHAR_X10 * c.len;
    endcase
    return tenths(t);
  endfunction

  // ready registered one step ahead so the port comes straight from a flop
  assign cmd_ready_o = st_reg.rdy;
  assign mem_o = st_reg.mem;
  assign icount_o = st_reg.icnt;
  assign icount_load_o = st_reg.icnt_ld;
  assign done_o = st_reg.done;
  assign time_o = st_reg.tm;
  assign fifo_push = st_reg.fsm == S_RDW && mem_ack_i;
  assign fifo_pop = st_reg.fsm == S_WR && fifo_v;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.icnt_ld = 1'b0;
    case (st_reg.fsm)
      S_IDLE: if (cmd_valid_i) begin
        st_next.cmd = cmd_i;
        st_next.ea = cmd_i.addr + ((cmd_i.idx_sel == 3'h0) ? '0 : index_i[cmd_i.idx_sel]);
        st_next.acc = '0;
        st_next.byte_i = '0;
        st_next.icnt = icount_i;
        if (cmd_i.op == cfx_pkg::CFX_OP_ZS_TIME) begin
          st_next.tm = op_time(cmd_i, '0);
          st_next.fsm = S_DONE;
        end else if (is_blk(cmd_i.op)) begin
          st_next.wsel = 2'd0;
          st_next.fsm = S_SAVE;
        end else if (cmd_i.op inside {cfx_pkg::CFX_OP_PAD_ZEROS, cfx_pkg::CFX_OP_PAD_BLANKS})
        begin
          st_next.left = cfx_pkg::CNT_W'(cmd_i.len);
          st_next.fsm = S_FILL;
        end else begin
          st_next.rd_n = (cmd_i.op == cfx_pkg::CFX_OP_SHIFT) ? 3'(cmd_i.n_code) + 3'd1 : 3'd1;
          st_next.left = cfx_pkg::CNT_W'(st_next.rd_n);
          st_next.src = st_next.ea;
          st_next.fsm = S_RD;
        end
      end
      S_SAVE: begin
        st_next.mem = '{req: 1'b1, we: 1'b1, addr: cfx_pkg::SAVE_ADDR,
                        wdata: st_reg.icnt[cfx_pkg::CHAR_W-1:0]};
        if (mem_ack_i) begin
          st_next.mem = '0;
          st_next.fsm = S_LDW;
        end
      end
      // fetch pointer then count low characters
      S_LDW: begin
        st_next.mem = '{req: 1'b1, we: 1'b0, wdata: '0,
          addr: (st_reg.wsel == 2'd2) ? cfx_pkg::CNT_ADDR :
                (is_from(st_reg.cmd.op) ? cfx_pkg::DST_ADDR : cfx_pkg::SRC_ADDR)};
        if (mem_ack_i) begin
          st_next.mem = '0;
          st_next.fsm = S_LDWAIT;
          if (st_reg.wsel == 2'd2) st_next.left = {4'h0, mem_rdata_i};
          else st_next.word = {9'h0, mem_rdata_i};
        end
      end
      S_LDWAIT: begin
        if (st_reg.wsel == 2'd2) begin
          st_next.total = st_reg.left;
          st_next.ptr0 = st_reg.word;
          st_next.src = is_from(st_reg.cmd.op) ? st_reg.ea : st_reg.word;
          st_next.dst = is_from(st_reg.cmd.op) ? st_reg.word : st_reg.ea;
          st_next.fsm = (st_reg.left == '0) ? S_PTRW : S_RD;
          st_next.rd_n = '0;
        end else begin
          st_next.wsel = 2'd2;
          st_next.fsm = S_LDW;
        end
      end
      // pad run from ea-L+1 up to ea
      S_FILL: begin
        st_next.mem = '{req: 1'b1, we: 1'b1,
          addr: st_reg.ea - cfx_pkg::ADDR_W'(st_reg.left) + 1'b1,
          wdata: (st_reg.cmd.op == cfx_pkg::CFX_OP_PAD_ZEROS) ? cfx_pkg::CH_ZERO
                                                              : cfx_pkg::CH_BLANK};
        if (mem_ack_i) begin
          st_next.mem = '0;
          st_next.left = st_reg.left - 1'b1;
          if (st_reg.left == 10'd1) begin
            st_next.tm = op_time(st_reg.cmd, '0);
            st_next.fsm = S_DONE;
          end
        end
      end
      // ascending reads, bounded by fifo space
      S_RD: if (fifo_rdy) begin
        st_next.mem = '{req: 1'b1, we: 1'b0, addr: st_reg.src, wdata: '0};
        st_next.fsm = S_RDW;
      end
      S_RDW: if (mem_ack_i) begin
        st_next.mem = '0;
        st_next.src = st_reg.src + 1'b1;
        st_next.fsm = S_WR;
      end
      S_WR: if (fifo_v) begin
        if (is_blk(st_reg.cmd.op)) begin
          st_next.mem = '{req: 1'b1, we: 1'b1, addr: st_reg.dst, wdata: fifo_d};
          st_next.fsm = S_WRW;
        end else begin
          st_next.acc = {st_reg.acc[17:0], fifo_d};
          st_next.left = st_reg.left - 1'b1;
          st_next.fsm = (st_reg.left == 10'd1) ? S_WRW : S_RD;
          st_next.byte_i = '0;
        end
      end
      S_WRW: begin
        if (is_blk(st_reg.cmd.op)) begin
          if (mem_ack_i) begin
            st_next.mem = '0;
            st_next.dst = st_reg.dst + 1'b1;
            st_next.left = st_reg.left - 1'b1;
            st_next.fsm = (st_reg.left == 10'd1) ? S_PTRW : S_RD;
          end
        end else begin
          logic [23:0] r;
          r = st_reg.acc;
          if (st_reg.cmd.op == cfx_pkg::CFX_OP_OR) r[5:0] = st_reg.acc[5:0] | st_reg.cmd.konst;
          else if (st_reg.cmd.op == cfx_pkg::CFX_OP_AND)
            r[5:0] = st_reg.acc[5:0] & st_reg.cmd.konst;
          // shift within 6*n bits, zero fill
          else r = (st_reg.acc << st_reg.cmd.shift) &
                   ((24'h1 << (6 * st_reg.rd_n)) - 24'h1);
          st_next.mem = '{req: 1'b1, we: 1'b1,
            addr: st_reg.ea + cfx_pkg::ADDR_W'(st_reg.byte_i),
            wdata: r[6*(st_reg.rd_n - 3'(st_reg.byte_i) - 1) +: 6]};
          if (mem_ack_i) begin
            st_next.mem = '0;
            st_next.byte_i = st_reg.byte_i + 1'b1;
            if (3'(st_reg.byte_i) + 3'd1 == st_reg.rd_n) begin
              st_next.tm = op_time(st_reg.cmd, '0);
              st_next.fsm = S_DONE;
            end
          end
        end
      end
      // pointer write back; count word untouched
      S_PTRW: begin
        st_next.mem = '{req: 1'b1, we: 1'b1,
          addr: is_from(st_reg.cmd.op) ? cfx_pkg::DST_ADDR : cfx_pkg::SRC_ADDR,
          wdata: is_inc(st_reg.cmd.op)
                 ? (is_from(st_reg.cmd.op) ? st_reg.dst[5:0] : st_reg.src[5:0])
                 : st_reg.ptr0[5:0]};
        if (mem_ack_i) begin
          st_next.mem = '0;
          st_next.fsm = S_REST;
        end
      end
      S_REST: begin
        st_next.mem = '{req: 1'b1, we: 1'b0, addr: cfx_pkg::SAVE_ADDR, wdata: '0};
        if (mem_ack_i) begin
          st_next.mem = '0;
          // saved word holds one character; upper counter bits kept from entry
          st_next.icnt = {st_reg.icnt[cfx_pkg::ADDR_W-1:cfx_pkg::CHAR_W], mem_rdata_i};
          st_next.icnt_ld = 1'b1;
          st_next.tm = op_time(st_reg.cmd, st_reg.total);
          st_next.fsm = S_DONE;
        end
      end
      S_DONE: begin
        st_next.done = 1'b1;
        st_next.fsm = S_IDLE;
      end
      default: st_next.fsm = S_IDLE;
    endcase
    st_next.rdy = st_next.fsm == S_IDLE;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg     <= '0;
      st_reg.rdy <= 1'b1;
    end else st_reg <= st_next;
  end

  property p_done_pulse;
    @(posedge sys_clk_i) disable iff (!nrst_i) done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held");
  property p_no_cnt_write;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (mem_o.req && mem_o.we) |-> mem_o.addr != cfx_pkg::CNT_ADDR;
  endproperty
  a_no_cnt_write: assert property (p_no_cnt_write) else $error("count written");

  property p_ea_plain;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (cmd_valid_i && cmd_ready_o && cmd_i.idx_sel == 3'h0)
      |=> st_reg.ea == $past(cmd_i.addr);
  endproperty
  a_ea_plain: assert property (p_ea_plain) else $error("index added for selector zero");

  sequence s_zs_taken;
    cmd_valid_i && cmd_ready_o && cmd_i.op == cfx_pkg::CFX_OP_ZS_TIME;
  endsequence
  property p_zs_quick;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_zs_taken |-> ##2 done_o;
  endproperty
  a_zs_quick: assert property (p_zs_quick) else $error("zero suppress time late");

  sequence s_restore_ack;
    st_reg.fsm == S_REST && mem_ack_i;
  endsequence
  sequence s_load_then_done;
    icount_load_o ##1 done_o;
  endsequence
  property p_restore;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_restore_ack |=>
        (icount_o[cfx_pkg::CHAR_W-1:0] == $past(mem_rdata_i)) ##0 s_load_then_done;
  endproperty
  a_restore: assert property (p_restore) else $error("counter not restored");

  sequence s_blk_write_ack;
    st_reg.fsm == S_WRW && is_blk(st_reg.cmd.op) && mem_ack_i;
  endsequence
  property p_ascend;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      s_blk_write_ack |=> st_reg.dst == cfx_pkg::ADDR_W'($past(st_reg.dst) + 1'b1);
  endproperty
  a_ascend: assert property (p_ascend) else $error("destination not ascending");

  property p_shift_fill;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (st_reg.fsm == S_WRW && st_reg.cmd.op == cfx_pkg::CFX_OP_SHIFT && mem_o.req &&
       3'(st_reg.byte_i) + 3'd1 == st_reg.rd_n)
      |-> (mem_o.wdata & ((6'h1 << st_reg.cmd.shift) - 6'h1)) == 6'h0;
  endproperty
  a_shift_fill: assert property (p_shift_fill) else $error("shift fill not zero");

  // pad writes only its fill character
  property p_pad_char;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (st_reg.fsm == S_FILL && mem_o.req) |-> mem_o.we && mem_o.wdata ==
        ((st_reg.cmd.op == cfx_pkg::CFX_OP_PAD_ZEROS) ? cfx_pkg::CH_ZERO : cfx_pkg::CH_BLANK);
  endproperty
  a_pad_char: assert property (p_pad_char) else $error("wrong pad character");
endmodule

// ---- hw/cfx_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cfx_fifo #(
  parameter int unsigned WIDTH = 6,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } cfx_fifo_st_t;
  cfx_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign push = in_valid_i && (st_reg.cnt != (PW+1)'(DEPTH));
  assign pop  = out_ready_i && (st_reg.cnt != '0);
  assign in_ready_o  = st_reg.cnt != (PW+1)'(DEPTH);
  assign out_valid_o = st_reg.cnt != '0;
  assign out_data_o  = mem[st_reg.rp];
  always_comb begin
    st_next = st_reg;
    if (push) st_next.wp = st_reg.wp + 1'b1;
    if (pop) st_next.rp = st_reg.rp + 1'b1;
    st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) st_reg <= '0;
    else st_reg <= st_next;
  end
  always_ff @(posedge sys_clk_i) begin
    if (push) mem[st_reg.wp] <= in_data_i;
  end
endmodule

// ---- hw/cfx_pkg.sv ----
// constants, types and timing for the character field execution block
// Function
// - pad writes zero or blank into L positions ending at effective address
// - zero suppress time is 45 plus 9 per character, dollar adds, length 16 subtracts
// - block count is the six-bit count character, zero-extended to ten bits
// - from-memory forms read at effective address, write at destination pointer
// - to-memory forms write at effective address, read at source pointer
// - block transfer copies characters in ascending address order
// - block transfer never writes the count word
// - counter saved in word 19 during transfer, restored from it at the end
// - from-memory reset form leaves destination pointer unchanged
// - from-memory increment form sets destination pointer to last written plus one
// - to-memory reset form leaves source pointer unchanged
// - to-memory increment form sets source pointer to last read plus one
// - transfer time 90 or 103.5 plus 9 per character
// - logical operations combine six-bit characters bitwise without carries
// - logical or writes constant OR character back, time 40.5
// - logical and writes constant AND character back
// - shift works on 1 to 4 characters by at most 7 bits
// - left shift drops top bits, fills low bits with zeros, stores result
// - transfer, logical and shift operands are index modified
// - shift time 40.5 plus count times (9 plus 18 times code)
package cfx_pkg;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned CHAR_W      = 6;
  localparam int unsigned CNT_W       = 10;
  localparam int unsigned IDX_N       = 8;
  localparam logic [ADDR_W-1:0] DST_ADDR = 15'h0040;
  localparam logic [ADDR_W-1:0] SRC_ADDR = 15'h0044;
  localparam logic [ADDR_W-1:0] CNT_ADDR = 15'h0048;
  localparam logic [ADDR_W-1:0] SAVE_ADDR = 15'h004c;
  localparam logic [CHAR_W-1:0] CH_ZERO  = 6'h00;
  localparam logic [CHAR_W-1:0] CH_BLANK = 6'h05;
  localparam int unsigned CLK_PS      = 4000;
  // times in tenths of a unit-microsecond on the 4 ns clock, one unit = 1 cycle
  localparam int unsigned T_ZS_BASE_X10  = 450;
  localparam int unsigned T_ZS_CHAR_X10  = 90;
  localparam int unsigned T_ZS_ADJ_X10   = 45;
  localparam int unsigned T_BT_RST_X10   = 900;
  localparam int unsigned T_BT_INC_X10   = 1035;
  localparam int unsigned T_BT_CHAR_X10  = 90;
  localparam int unsigned T_LOG_X10      = 405;
  localparam int unsigned T_SH_BASE_X10  = 405;
  localparam int unsigned T_SH_BIT_X10   = 90;
  localparam int unsigned T_SH_CODE_X10  = 180;
  localparam int unsigned T_PAD_BASE_X10 = 270;
  localparam int unsigned T_PAD_CHAR_X10 = 45;
  localparam int unsigned ZS_FULL_LEN    = 16;
  localparam int unsigned ZS_LEN_W       = 5;
  localparam int unsigned TIME_W         = 16;
  localparam int unsigned FIFO_DEPTH     = 4;
  typedef enum logic [3:0] {
    CFX_OP_PAD_ZEROS, CFX_OP_PAD_BLANKS, CFX_OP_ZS_TIME, CFX_OP_FROM_RST,
    CFX_OP_FROM_INC, CFX_OP_TO_RST, CFX_OP_TO_INC, CFX_OP_OR, CFX_OP_AND,
    CFX_OP_SHIFT
  } cfx_op_t;
  typedef struct packed {
    cfx_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        idx_sel;
    logic [4:0]        len;
    logic [CHAR_W-1:0] konst;
    logic [1:0]        n_code;
    logic [2:0]        shift;
    logic              dollar;
  } cfx_cmd_t;
  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [CHAR_W-1:0] wdata;
  } cfx_mem_req_t;
endpackage
